// File: verilog/bhp_master.sv
// Byte-wide host port master: drives a DSP's 8-bit host port with 16-bit accesses.
// Assumes APB master on pclk, slave host port synchronous to pclk, one clock domain.
// Behaviour
// - Writes to the slave's control register drive host_access_select to 00.
// - Write accesses keep read_not_write low across both bytes.
// - Burst read accesses keep read_not_write high across both bytes.
// - Bursts drive byte_half_select low in S0-S1 and high in S2-S3.
// - A full 16-bit burst access, with both bytes and trailing delays, spans S0 to S5.
// - The next access starts after the fixed S4-S5 delay, whether or not the slave's ready has returned high.
// - Ready is waited out by fixed delay states S4 and S5, not sampled.
// - S5 checks transfer_count_expired; continue if not expired, else end burst.
// - Register writes use two single-byte waveforms separated by an idle gap.
// - Single writes drive byte_half_select low on byte one, high on byte two.
`timescale 1ns/10ps
module bhp_master
	import bhp_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Host port pins
	output logic [1:0] host_access_select,
	output logic read_not_write,
	output logic byte_half_select,
	output logic data_strobe_n,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe_n,
	input wire logic host_port_ready
);
	typedef struct packed {
		bhp_state_t state;
		logic [3:0] tick;
		logic [15:0] count;
		logic expired;
		logic rd;
		logic single;
		logic second;
		logic [1:0] sel;
		logic [15:0] regval;
		logic [15:0] word;
		logic [7:0] low_byte;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] hsel;
		logic rnw;
		logic half;
		logic strobe_n;
		logic [7:0] dout;
		logic oe;
	} bhp_st_t;
	bhp_st_t st_r, st_nxt;

	logic wf_in_valid, wf_in_ready, wf_out_valid, wf_out_ready;
	logic rf_in_valid, rf_in_ready, rf_out_valid, rf_out_ready;
	logic [15:0] wf_out_data, rf_out_data, rf_in_data;
	logic apb_setup, apb_wr, apb_rd;
	logic busy, tick_done;
	logic burst_wr, burst_rd;

	assign apb_setup = psel && !penable;
	assign apb_wr = apb_setup && pwrite;
	assign apb_rd = apb_setup && !pwrite;
	assign busy = (st_r.state != BHP_IDLE);
	assign tick_done = (st_r.tick == BHP_STATE_CYC - 4'h1);
	// Bursts move FIFO words; singles only carry the staged register value
	assign burst_wr = !st_r.single && !st_r.rd;
	assign burst_rd = !st_r.single && st_r.rd;
	assign wf_in_valid = apb_wr && (paddr == BHP_WDATA_OFF);
	assign rf_out_ready = apb_rd && (paddr == BHP_RDATA_OFF);
	assign rf_in_data = {host_data_in, st_r.low_byte};

	// Write data path: software fills, port drains
	bhp_fifo #(.WIDTH(BHP_FIFO_W), .DEPTH(BHP_FIFO_D)) u_wr_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.ce(pce),
		.in_valid(wf_in_valid),
		.in_ready(wf_in_ready),
		.in_data(pwdata[15:0]),
		.out_valid(wf_out_valid),
		.out_ready(wf_out_ready),
		.out_data(wf_out_data)
	);

	// Read data path: port fills, software drains
	bhp_fifo #(.WIDTH(BHP_FIFO_W), .DEPTH(BHP_FIFO_D)) u_rd_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.ce(pce),
		.in_valid(rf_in_valid),
		.in_ready(rf_in_ready),
		.in_data(rf_in_data),
		.out_valid(rf_out_valid),
		.out_ready(rf_out_ready),
		.out_data(rf_out_data)
	);

	// Write word leaves the FIFO in the first S0 cycle, once it is latched;
	// popping at the end of the access would strand the last word of a burst
	always_comb begin
		wf_out_ready = 1'b0;
		rf_in_valid = 1'b0;
		if (st_r.state == BHP_S0 && st_r.tick == 4'h0 && burst_wr) begin
			wf_out_ready = 1'b1;
		end
		// Read word enters the FIFO once its high byte has been sampled
		if (st_r.state == BHP_S3 && tick_done && burst_rd) begin
			rf_in_valid = 1'b1;
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		// APB answers one cycle after setup
		if (apb_setup) begin
			st_nxt.pready = 1'b1;
			st_nxt.prdata = 32'h0000_0000;
			case (paddr)
				BHP_CTRL_OFF: begin
					// Start refused while busy, so a running burst keeps its settings
					if (pwrite && !busy && pwdata[BHP_CTRL_GO_BIT]) begin
						st_nxt.rd = pwdata[BHP_CTRL_READ_BIT];
						st_nxt.single = pwdata[BHP_CTRL_SINGLE_BIT];
						st_nxt.sel = pwdata[BHP_CTRL_SEL_LSB +: 2];
						st_nxt.expired = (st_r.count == 16'h0000);
						st_nxt.second = 1'b0;
						if (st_r.count != 16'h0000 || pwdata[BHP_CTRL_SINGLE_BIT]) begin
							// Burst write with an empty FIFO has nothing to send
							if (pwdata[BHP_CTRL_SINGLE_BIT] || pwdata[BHP_CTRL_READ_BIT]) begin
								st_nxt.state = BHP_S0;
							end else if (wf_out_valid) begin
								st_nxt.state = BHP_S0;
							end
						end
						st_nxt.tick = 4'h0;
					end
					st_nxt.prdata[BHP_CTRL_READ_BIT] = st_r.rd;
					st_nxt.prdata[BHP_CTRL_SINGLE_BIT] = st_r.single;
					st_nxt.prdata[BHP_CTRL_SEL_LSB +: 2] = st_r.sel;
				end
				BHP_COUNT_OFF: begin
					if (pwrite && !busy)
						st_nxt.count = pwdata[15:0];
					st_nxt.prdata[15:0] = st_r.count;
				end
				BHP_REGVAL_OFF: begin
					if (pwrite && !busy)
						st_nxt.regval = pwdata[15:0];
					st_nxt.prdata[15:0] = st_r.regval;
				end
				BHP_WDATA_OFF: begin
					st_nxt.pslverr = pwrite && !wf_in_ready;
				end
				BHP_RDATA_OFF: begin
					st_nxt.prdata[15:0] = rf_out_data;
					st_nxt.pslverr = !pwrite && !rf_out_valid;
				end
				BHP_STATUS_OFF: begin
					st_nxt.prdata[BHP_ST_BUSY_BIT] = busy;
					st_nxt.prdata[BHP_ST_EXPIRED_BIT] = st_r.expired;
					st_nxt.prdata[BHP_ST_RVALID_BIT] = rf_out_valid;
					st_nxt.prdata[BHP_ST_WREADY_BIT] = wf_in_ready;
					// Live ready is for software only; the engine never waits on it
					st_nxt.prdata[BHP_ST_READY_BIT] = host_port_ready;
				end
				default: st_nxt.pslverr = 1'b1;
			endcase
		end
		// Waveform engine: each of S0 to S5 lasts BHP_STATE_CYC cycles unless S5 stalls; the gap lasts BHP_IDLE_CYC
		if (busy) begin
			st_nxt.tick = tick_done ? 4'h0 : st_r.tick + 4'h1;
		end
		// Pins are registered, so each lags its state by one cycle
		case (st_r.state)
			BHP_IDLE: begin
				st_nxt.strobe_n = 1'b1;
				st_nxt.oe = 1'b1;
			end
			BHP_S0: begin
				st_nxt.hsel = st_r.single ? st_r.sel : BHP_SEL_DATA_AUTO;
				st_nxt.rnw = st_r.rd && !st_r.single;
				st_nxt.half = st_r.single ? st_r.second : 1'b0;
				st_nxt.strobe_n = 1'b0;
				st_nxt.oe = st_r.rd && !st_r.single;
				if (st_r.single) begin
					st_nxt.dout = st_r.second ? st_r.regval[15:8] : st_r.regval[7:0];
				end else if (st_r.tick == 4'h0) begin
					// Head word is popped this cycle; keep a copy for both bytes
					st_nxt.word = wf_out_data;
					st_nxt.dout = wf_out_data[7:0];
				end else begin
					st_nxt.dout = st_r.word[7:0];
				end
				if (tick_done)
					st_nxt.state = BHP_S1;
			end
			BHP_S1: begin
				st_nxt.strobe_n = 1'b1;
				if (tick_done) begin
					// Low byte is taken just before the strobe for byte two
					if (st_r.rd)
						st_nxt.low_byte = host_data_in;
					if (st_r.single) begin
						st_nxt.state = st_r.second ? BHP_IDLE : BHP_GAP;
						st_nxt.second = !st_r.second;
						// Data pins released over the idle gap
						st_nxt.oe = 1'b1;
					end else begin
						st_nxt.state = BHP_S2;
					end
				end
			end
			BHP_S2: begin
				st_nxt.half = 1'b1;
				st_nxt.strobe_n = 1'b0;
				st_nxt.dout = st_r.word[15:8];
				if (tick_done)
					st_nxt.state = BHP_S3;
			end
			BHP_S3: begin
				st_nxt.strobe_n = 1'b1;
				if (tick_done) begin
					st_nxt.state = BHP_S4;
					st_nxt.oe = 1'b1;
					// Singles never reach S3, so they leave the count alone
					st_nxt.count = st_r.count - 16'h0001;
					st_nxt.expired = (st_r.count == 16'h0001);
				end
			end
			BHP_S4: begin
				// Fixed delay covers the slave's not-ready window
				if (tick_done)
					st_nxt.state = BHP_S5;
			end
			BHP_S5: begin
				if (tick_done) begin
					// Read stalls if its FIFO is full; write stalls until data arrives
					if (st_r.expired)
						st_nxt.state = BHP_IDLE;
					else if (st_r.rd ? rf_in_ready : wf_out_valid)
						st_nxt.state = BHP_S0;
					else
						st_nxt.tick = st_r.tick;
				end
			end
			BHP_GAP: begin
				st_nxt.hsel = st_r.sel;
				st_nxt.rnw = 1'b0;
				// Gap outlasts a state, so it keeps its own count past the state wrap
				st_nxt.tick = st_r.tick + 4'h1;
				if (st_r.tick == BHP_IDLE_CYC - 4'h1) begin
					st_nxt.state = BHP_S0;
					st_nxt.tick = 4'h0;
				end
			end
			default: st_nxt.state = BHP_IDLE;
		endcase
		if (st_r.state == BHP_IDLE || st_r.state == BHP_GAP) begin
			st_nxt.hsel = (st_r.state == BHP_GAP) ? st_r.sel : BHP_SEL_RST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.state <= BHP_IDLE;
			st_r.count <= BHP_COUNT_RST;
			// Idle pins: strobe high, data pins released
			st_r.strobe_n <= 1'b1;
			st_r.oe <= 1'b1;
		end else if (pce) begin
			st_r <= st_nxt;
		end
	end

	// Every answer and pin comes straight from the state register
	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign host_access_select = st_r.hsel;
	assign read_not_write = st_r.rnw;
	assign byte_half_select = st_r.half;
	assign data_strobe_n = st_r.strobe_n;
	assign host_data_out = st_r.dout;
	assign host_data_oe_n = st_r.oe;
endmodule : bhp_master

// File: verilog/bhp_pkg.sv
// Package for the byte-wide host port master: register map, states, timing.
// Assumes a 25 MHz pclk and an APB register bus with 32-bit data.
package bhp_pkg;
	// APB byte offsets
	localparam logic [7:0] BHP_CTRL_OFF = 8'h00;
	localparam logic [7:0] BHP_COUNT_OFF = 8'h04;
	localparam logic [7:0] BHP_REGVAL_OFF = 8'h08;
	localparam logic [7:0] BHP_WDATA_OFF = 8'h0C;
	localparam logic [7:0] BHP_RDATA_OFF = 8'h10;
	localparam logic [7:0] BHP_STATUS_OFF = 8'h14;
	// Control register fields
	localparam int BHP_CTRL_GO_BIT = 0;
	localparam int BHP_CTRL_READ_BIT = 1;
	localparam int BHP_CTRL_SINGLE_BIT = 2;
	localparam int BHP_CTRL_SEL_LSB = 4;
	// Status register fields
	localparam int BHP_ST_BUSY_BIT = 0;
	localparam int BHP_ST_EXPIRED_BIT = 1;
	localparam int BHP_ST_RVALID_BIT = 2;
	localparam int BHP_ST_WREADY_BIT = 3;
	localparam int BHP_ST_READY_BIT = 4;
	// Host access select codes
	localparam logic [1:0] BHP_SEL_CONTROL = 2'h0;
	localparam logic [1:0] BHP_SEL_DATA_AUTO = 2'h1;
	// Reset values
	localparam logic [15:0] BHP_COUNT_RST = 16'h0000;
	localparam logic [1:0] BHP_SEL_RST = 2'h0;
	// Timing: each waveform state lasts half a strobe period
	localparam int BHP_CLK_MHZ = 25;
	localparam int BHP_STATE_NS = 80;
	localparam int BHP_STATE_CYC_I = (BHP_STATE_NS * BHP_CLK_MHZ + 999) / 1000;
	localparam logic [3:0] BHP_STATE_CYC = 4'(BHP_STATE_CYC_I);
	// Idle gap between the two single-write waveforms
	localparam int BHP_IDLE_NS = 400;
	localparam int BHP_IDLE_CYC_I = (BHP_IDLE_NS * BHP_CLK_MHZ + 999) / 1000;
	localparam logic [3:0] BHP_IDLE_CYC = 4'(BHP_IDLE_CYC_I);
	// FIFO geometry
	localparam int BHP_FIFO_W = 16;
	localparam int BHP_FIFO_D = 8;
	typedef enum logic [7:0] {
		BHP_IDLE = 8'h01,
		BHP_S0 = 8'h02,
		BHP_S1 = 8'h04,
		BHP_S2 = 8'h08,
		BHP_S3 = 8'h10,
		BHP_S4 = 8'h20,
		BHP_S5 = 8'h40,
		BHP_GAP = 8'h80
	} bhp_state_t;
endpackage : bhp_pkg

// File: verilog/bhp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; write and read may happen in the same cycle.
`timescale 1ns/10ps
module bhp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} bhp_fifo_st_t;
	bhp_fifo_st_t st_r, st_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_r.cnt != '0);
	assign out_data = mem[st_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		st_nxt = st_r;
		if (push)
			st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
		if (pop)
			st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
		if (push && !pop)
			st_nxt.cnt = st_r.cnt + 1'b1;
		else if (pop && !push)
			st_nxt.cnt = st_r.cnt - 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	// Storage carries no reset; only pointers need a defined value
	always_ff @(posedge clk) begin
		if (ce && push)
			mem[st_r.wp] <= in_data;
	end
endmodule : bhp_fifo

// File: testbench/bhp_master_monitor.sv
// Checker on the host port master's ports.
// Assumes one clock domain, pce held high by the bench.
`timescale 1ns/10ps
module bhp_master_monitor
	import bhp_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Host port pins
	input wire logic [1:0] host_access_select,
	input wire logic read_not_write,
	input wire logic byte_half_select,
	input wire logic data_strobe_n,
	input wire logic host_data_oe_n
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_apb_answer: assert property (psel && !penable |=> pready) else $error("no pready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_strobe_width: assert property (
		$fell(data_strobe_n) |-> ##1 !data_strobe_n ##1 data_strobe_n) else $error("strobe width");
	a_burst_halves: assert property (
		$fell(data_strobe_n) && !byte_half_select && host_access_select == BHP_SEL_DATA_AUTO
		|-> ##4 ($fell(data_strobe_n) && byte_half_select)) else $error("burst halves");
	a_single_halves: assert property (
		$fell(data_strobe_n) && !byte_half_select
		|-> ##[4:30] ($fell(data_strobe_n) && byte_half_select)) else $error("no second byte");
	a_access_space: assert property (
		$fell(data_strobe_n) && !byte_half_select
		|=> !($fell(data_strobe_n) && !byte_half_select) [*8]
		##1 !($fell(data_strobe_n) && !byte_half_select) [*3]) else $error("access too soon");
	a_write_hold: assert property (
		$fell(data_strobe_n) && !byte_half_select && !read_not_write
		|-> !read_not_write [*8]) else $error("write direction lost");
	a_read_hold: assert property (
		$fell(data_strobe_n) && !byte_half_select && read_not_write
		|-> read_not_write [*8]) else $error("read direction lost");
	a_read_no_drive: assert property (
		read_not_write |-> host_data_oe_n) else $error("drives pins on read");
endmodule : bhp_master_monitor
bind bhp_master bhp_master_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready,
	.host_access_select, .read_not_write, .byte_half_select, .data_strobe_n, .host_data_oe_n);

// File: testbench/bhp_hpi_model.sv
// Behavioural slave of the 8-bit host port.
// Assumes the master's pins are synchronous to clk.
`timescale 1ns/10ps
module bhp_hpi_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host port pins
	input wire logic read_not_write,
	input wire logic byte_half_select,
	input wire logic data_strobe_n,
	input wire logic [7:0] host_data_out,
	output logic [7:0] host_data_in,
	output logic host_port_ready
);
	logic strb_q;
	logic [1:0] busy_cnt;
	logic [15:0] rd_word;
	logic [15:0] wr_word;
	int num_wr;
	int viol;
	// Off-read the pins show garbage, never a held value
	assign host_data_in = !read_not_write ? ~host_data_out :
		(byte_half_select ? rd_word[15:8] : rd_word[7:0]);
	assign host_port_ready = (busy_cnt == 2'h0);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strb_q <= 1'b1;
			busy_cnt <= 2'h0;
			rd_word <= 16'hA500;
			wr_word <= 16'h0000;
			num_wr <= 0;
			viol <= 0;
		end else begin
			strb_q <= data_strobe_n;
			if (busy_cnt != 2'h0) begin
				busy_cnt <= busy_cnt - 2'h1;
				if (busy_cnt == 2'h1 && read_not_write) begin
					rd_word <= rd_word + 16'h0001;
				end
			end
			if (!data_strobe_n && strb_q && busy_cnt != 2'h0) begin
				viol <= viol + 1;
			end
			if (!data_strobe_n && !read_not_write) begin
				if (byte_half_select) begin
					wr_word[15:8] <= host_data_out;
				end else begin
					wr_word[7:0] <= host_data_out;
				end
			end
			if (data_strobe_n && !strb_q && byte_half_select) begin
				busy_cnt <= 2'h3;
				if (!read_not_write) begin
					num_wr <= num_wr + 1;
				end
			end
		end
	end
endmodule : bhp_hpi_model

// File: testbench/tb.sv
// Self-checking bench: APB tasks drive single, burst write and burst read accesses.
// Assumes the host port model answers on the far side.
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED at %0t: got %h", $time, got); end end
module tb;
	import bhp_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic [1:0] host_access_select;
	logic read_not_write, byte_half_select, data_strobe_n, host_data_oe_n, host_port_ready;
	logic [7:0] host_data_in, host_data_out;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	bhp_master DUT (.pclk, .presetn, .pce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .host_access_select, .read_not_write, .byte_half_select,
		.data_strobe_n, .host_data_in, .host_data_out, .host_data_oe_n, .host_port_ready);
	bhp_hpi_model slv (.clk(pclk), .rst_n(presetn), .read_not_write, .byte_half_select,
		.data_strobe_n, .host_data_out, .host_data_in, .host_port_ready);
	initial forever #20 pclk = ~pclk;
	task automatic results;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	// Hang guard well above the whole sequence
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_idle;
		do apb(1'b0, BHP_STATUS_OFF, 32'h0); while (rd[BHP_ST_BUSY_BIT] !== 1'b0);
	endtask : wait_idle
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK({host_access_select, data_strobe_n, host_data_oe_n}, 4'h3)
		apb(1'b0, BHP_COUNT_OFF, 32'h0);
		`CHK(rd[15:0], BHP_COUNT_RST)
		apb(1'b1, BHP_REGVAL_OFF, 32'h0000_3C5A);
		apb(1'b1, BHP_CTRL_OFF, 32'h0000_0005);
		@(negedge data_strobe_n);
		@(negedge pclk);
		`CHK(host_access_select, BHP_SEL_CONTROL)
		wait_idle();
		`CHK(slv.wr_word, 16'h3C5A)
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, BHP_WDATA_OFF, 32'h1100 + i);
			`CHK(err, i == 8)
		end
		apb(1'b1, BHP_COUNT_OFF, 32'h8);
		apb(1'b1, BHP_CTRL_OFF, 32'h11);
		wait_idle();
		`CHK(rd[BHP_ST_EXPIRED_BIT], 1'b1)
		`CHK(slv.num_wr, 9)
		`CHK(slv.wr_word, 16'h1107)
		apb(1'b0, BHP_COUNT_OFF, 32'h0);
		`CHK(rd[15:0], 16'h0000)
		// A word stranded by the last burst would go out first here
		for (int i = 0; i < 2; i++) apb(1'b1, BHP_WDATA_OFF, 32'h2200 + i);
		apb(1'b1, BHP_COUNT_OFF, 32'h2);
		apb(1'b1, BHP_CTRL_OFF, 32'h11);
		wait_idle();
		`CHK(slv.wr_word, 16'h2201)
		`CHK(slv.num_wr, 11)
		apb(1'b1, BHP_COUNT_OFF, 32'h2);
		apb(1'b1, BHP_CTRL_OFF, 32'h13);
		wait_idle();
		for (int i = 0; i < 2; i++) begin
			apb(1'b0, BHP_RDATA_OFF, 32'h0);
			`CHK(rd[15:0], 16'hA500 + i)
		end
		apb(1'b0, BHP_RDATA_OFF, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b0, 8'h20, 32'h0);
		`CHK(err, 1'b1)
		`CHK(slv.viol, 0)
		results();
	end
endmodule : tb
